// file: pkg/ram_ptr_pkg.sv
// Constants shared by the auto-increment RAM pointer design
`default_nettype none

package ram_ptr_pkg;

    // ********************************************************
    // Register addresses on the external-data bus
    // ********************************************************
    localparam logic [15:0] ADDR_PTR_HIGH   = 16'h7fe3;
    localparam logic [15:0] ADDR_PTR_LOW    = 16'h7fe4;
    localparam logic [15:0] ADDR_DATA_WIN   = 16'h7fe5;

    // ********************************************************
    // Field layout and reset values
    // ********************************************************
    localparam int          PTR_HIGH_LSB    = 8;
    localparam logic [15:0] PTR_RESET       = 16'h0000;
    localparam logic [7:0]  BYTE_RESET      = 8'h00;
    localparam logic [15:0] PTR_ONE         = 16'h0001;

    // Top of internal program/data RAM; nothing above is reachable
    localparam logic [15:0] RAM_TOP         = 16'h1fff;

    // ********************************************************
    // Timing: fast transfer must finish within two processor cycles (333 ns, 16 core cycles)
    // ********************************************************
    localparam int          CLK_PERIOD_NS   = 20;
    localparam int          FAST_XFER_NS    = 333;
    localparam int          FAST_XFER_CYC   = FAST_XFER_NS / CLK_PERIOD_NS;

    // ********************************************************
    // Access sequencer states
    // ********************************************************
    typedef enum logic [2:0]
    {
        ST_IDLE   = 3'b001,
        ST_ACCESS = 3'b010,
        ST_ANSWER = 3'b100
    } seq_state_e;

endpackage

`default_nettype wire

// file: design/ptr_counter.sv
// Sixteen-bit pointer with byte loads and post-increment
`timescale 1ns/1ps
`default_nettype none

module ptr_counter
(
    // Clock and reset
    input  wire logic        i_core_clk,
    input  wire logic        i_rst_b,
    // Byte loads from the processor
    input  wire logic        i_load_high,
    input  wire logic        i_load_low,
    input  wire logic [7:0]  i_load_data,
    // Advance after a data window access
    input  wire logic        i_incr,
    // Live pointer
    output var  logic [15:0] o_ptr
);
    import ram_ptr_pkg::*;

    logic [15:0] ptr_next;

    // ********************************************************
    // Next pointer value
    // ********************************************************
    // A load wins over an increment; the sequencer never asks for both
    always_comb
    begin
        ptr_next = o_ptr;
        if (i_load_high)
            ptr_next[15:PTR_HIGH_LSB] = i_load_data;
        if (i_load_low)
            ptr_next[PTR_HIGH_LSB-1:0] = i_load_data;
        if (i_incr && !i_load_high && !i_load_low)
            ptr_next = o_ptr + PTR_ONE;
    end

    // Pointer flop; true reset value is undefined, zero is chosen
    always_ff @(posedge i_core_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
            o_ptr <= PTR_RESET;
        else
            o_ptr <= ptr_next;
    end

    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_rst_b);

    // Low byte carries into high byte and the pointer wraps at the top
    chk_ptr_wrap: assert property (
        (i_incr && !i_load_high && !i_load_low && o_ptr == 16'hffff)
        |=> o_ptr == PTR_RESET)
        else $error("pointer did not wrap to zero");

    chk_low_carry: assert property (
        (i_incr && !i_load_high && !i_load_low && o_ptr[7:0] == 8'hff)
        |=> o_ptr[15:8] == $past(o_ptr[15:8]) + 8'h01 && o_ptr[7:0] == 8'h00)
        else $error("low byte did not carry into high byte");

endmodule

`default_nettype wire

// file: design/ram_ptr_top.sv
// Auto-increment RAM pointer with data window and fast bulk transfer
//
// Notes on behaviour
// - Pointer address is high byte (bits 15..8) and low byte (bits 7..0).
// - Window read returns RAM byte at pointer; window write stores byte there.
// - Pointer advances by one after every window read and every window write.
// - Both pointer bytes may be read or written in any order while no window access is in progress.
// - Pointer byte reads give the live address the next window access uses.
// - Any contiguous internal RAM region is reachable as a sequential port.
// - Only internal RAM is reachable; nothing off chip or above it.
// - Fast mode needs enable set, window addressed, and an external move.
// - Fast mode moves one byte between bus and RAM within two processor cycles.
`timescale 1ns/1ps
`default_nettype none

module ram_ptr_top
(
    // Clock and reset
    input  wire logic        i_core_clk,
    input  wire logic        i_rst_b,
    // Processor external-data bus
    input  wire logic [15:0] i_xaddr,
    input  wire logic        i_xrd,
    input  wire logic        i_xwr,
    input  wire logic [7:0]  i_xwdata,
    output var  logic [7:0]  o_xrdata,
    output var  logic        o_xack,
    // Fast transfer control
    input  wire logic        i_fast_bulk_enable,
    // External memory data bus (two-way)
    input  wire logic [7:0]  i_ext_data,
    output var  logic [7:0]  o_ext_data,
    output var  logic        o_ext_data_oe,
    output var  logic        o_ext_strobe,
    // Internal RAM port
    output var  logic [15:0] o_ram_addr,
    output var  logic        o_ram_re,
    output var  logic        o_ram_we,
    output var  logic [7:0]  o_ram_wdata,
    input  wire logic [7:0]  i_ram_rdata
);
    import ram_ptr_pkg::*;

    // Bound for the fast-transfer deadline check
    localparam int FAST_LIMIT = FAST_XFER_CYC;

    // ********************************************************
    // Declarations
    // ********************************************************
    seq_state_e  state_reg;
    seq_state_e  state_next;
    logic [15:0] ptr;
    logic        op_read_reg;
    logic        op_fast_reg;
    logic        op_in_ram_reg;
    logic [7:0]  xrdata_next;
    logic        xack_next;

    wire         is_idle;
    wire         hit_high;
    wire         hit_low;
    wire         hit_win;
    wire         win_read;
    wire         win_write;
    wire         win_go;
    wire         fast_go;
    wire         ptr_in_ram;
    wire         load_high;
    wire         load_low;
    wire         read_high;
    wire         read_low;
    wire         reg_access;
    wire [7:0]   store_byte;
    wire         answer_cycle;
    wire         ext_strobe_next;
    wire         ext_oe_next;

    // ********************************************************
    // Address decode
    // ********************************************************
    // Requests are taken only while idle; a strobe mid-access is dropped
    assign is_idle   = (state_reg == ST_IDLE);
    assign hit_high  = (i_xaddr == ADDR_PTR_HIGH);
    assign hit_low   = (i_xaddr == ADDR_PTR_LOW);
    assign hit_win   = (i_xaddr == ADDR_DATA_WIN);

    // Window accesses drive the RAM and bump the pointer
    assign win_read  = is_idle & i_xrd & hit_win;
    assign win_write = is_idle & i_xwr & hit_win;
    assign win_go    = win_read | win_write;

    // Fast move only on a window access with fast bulk enabled
    assign fast_go   = win_go & i_fast_bulk_enable;

    // The whole internal RAM is open, so any block can be streamed
    assign ptr_in_ram = (ptr <= RAM_TOP);

    // Pointer byte loads and reads, allowed in any order
    assign load_high  = is_idle & i_xwr & hit_high;
    assign load_low   = is_idle & i_xwr & hit_low;
    assign read_high  = is_idle & i_xrd & hit_high;
    assign read_low   = is_idle & i_xrd & hit_low;
    assign reg_access = load_high | load_low | read_high | read_low;

    // In fast mode the stored byte comes from the external bus
    assign store_byte = fast_go ? i_ext_data : i_xwdata;

    // RAM data is valid in the cycle after the read enable
    assign answer_cycle = (state_reg == ST_ANSWER);

    // External bus handshake: write fast takes the byte at once,
    // read fast presents the RAM byte together with the answer
    assign ext_strobe_next = (win_write & fast_go)
                           | (answer_cycle & op_read_reg & op_fast_reg);
    assign ext_oe_next     = answer_cycle & op_read_reg & op_fast_reg;

    // ********************************************************
    // Pointer
    // ********************************************************
    ptr_counter u_ptr
    (
        .i_core_clk  (i_core_clk),
        .i_rst_b     (i_rst_b),
        .i_load_high (load_high),
        .i_load_low  (load_low),
        .i_load_data (i_xwdata),
        .i_incr      (win_go),
        .o_ptr       (ptr)
    );

    // ********************************************************
    // Access sequencer
    // ********************************************************
    // Three fixed steps keep the RAM read latency simple to follow
    always_comb
    begin
        state_next = state_reg;
        unique case (state_reg)
            ST_IDLE:
                if (win_go)
                    state_next = ST_ACCESS;
            ST_ACCESS:
                state_next = ST_ANSWER;
            ST_ANSWER:
                state_next = ST_IDLE;
            default:
                state_next = ST_IDLE;
        endcase
    end

    // Answer data: pointer bytes at once, RAM bytes when they land
    always_comb
    begin
        xrdata_next = o_xrdata;
        if (read_high)
            xrdata_next = ptr[15:PTR_HIGH_LSB];
        else if (read_low)
            xrdata_next = ptr[PTR_HIGH_LSB-1:0];
        else if (answer_cycle && op_read_reg)
            xrdata_next = op_in_ram_reg ? i_ram_rdata : BYTE_RESET;
        xack_next = reg_access | answer_cycle;
    end

    // Sequencer state and latched operation
    always_ff @(posedge i_core_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            state_reg     <= ST_IDLE;
            op_read_reg   <= 1'b0;
            op_fast_reg   <= 1'b0;
            op_in_ram_reg <= 1'b0;
        end
        else
        begin
            state_reg <= state_next;
            if (win_go)
            begin
                op_read_reg   <= win_read;
                op_fast_reg   <= fast_go;
                op_in_ram_reg <= ptr_in_ram;
            end
        end
    end

    // ********************************************************
    // RAM port
    // ********************************************************
    // Off-range pointers still advance but never strobe the RAM
    always_ff @(posedge i_core_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            o_ram_addr  <= PTR_RESET;
            o_ram_re    <= 1'b0;
            o_ram_we    <= 1'b0;
            o_ram_wdata <= BYTE_RESET;
        end
        else
        begin
            o_ram_re <= win_read & ptr_in_ram;
            o_ram_we <= win_write & ptr_in_ram;
            if (win_go)
            begin
                o_ram_addr  <= ptr;
                o_ram_wdata <= store_byte;
            end
        end
    end

    // ********************************************************
    // Processor answer and external bus
    // ********************************************************
    always_ff @(posedge i_core_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            o_xrdata      <= BYTE_RESET;
            o_xack        <= 1'b0;
            o_ext_data    <= BYTE_RESET;
            o_ext_data_oe <= 1'b0;
            o_ext_strobe  <= 1'b0;
        end
        else
        begin
            o_xrdata      <= xrdata_next;
            o_xack        <= xack_next;
            o_ext_strobe  <= ext_strobe_next;
            o_ext_data_oe <= ext_oe_next;
            if (ext_oe_next)
                o_ext_data <= xrdata_next;
        end
    end

    // ********************************************************
    // Checks
    // ********************************************************
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_rst_b);

    chk_ptr_advance: assert property (
        win_go |=> ptr == $past(ptr) + PTR_ONE)
        else $error("pointer did not advance after window access");

    chk_ram_addr: assert property (
        (win_go && ptr_in_ram) |=> o_ram_addr == $past(ptr) && (o_ram_re || o_ram_we))
        else $error("RAM access not at pointer address");

    chk_high_load: assert property (
        load_high |=> ptr[15:8] == $past(i_xwdata) && ptr[7:0] == $past(ptr[7:0]))
        else $error("high pointer byte load failed");

    chk_live_read: assert property (
        read_low |=> o_xack && o_xrdata == $past(ptr[7:0]))
        else $error("low pointer read not live value");

    chk_window_read: assert property (
        (win_read && ptr_in_ram) |=> ##1 !o_xack ##1 o_xack && o_xrdata == $past(i_ram_rdata))
        else $error("window read returned wrong byte or late");

    chk_ram_range: assert property (
        (win_go && !ptr_in_ram) |=> !o_ram_re && !o_ram_we)
        else $error("RAM strobed outside internal range");

    chk_fast_source: assert property (
        (win_write && fast_go) |=> o_ram_wdata == $past(i_ext_data) && o_ext_strobe)
        else $error("fast write did not take external byte");

    chk_slow_source: assert property (
        (win_write && !i_fast_bulk_enable) |=> o_ram_wdata == $past(i_xwdata) && !o_ext_strobe)
        else $error("normal write took wrong byte");

    chk_fast_deadline: assert property (
        (win_read && fast_go) |-> ##[1:FAST_LIMIT] (o_ext_strobe && o_ext_data_oe))
        else $error("fast read missed its deadline");

    // Window writes answer in the same slot as window reads
    chk_write_ack: assert property (
        win_write |=> ##1 !o_xack ##1 o_xack)
        else $error("window write answer late or missing");

    // Pointer byte loads are answered on the next cycle, in any order
    chk_load_ack: assert property (
        (load_high || load_low) |=> o_xack)
        else $error("pointer load not answered");

    // High byte reads give the live value as well
    chk_live_high: assert property (
        read_high |=> o_xack && o_xrdata == $past(ptr[15:8]))
        else $error("high pointer read not live value");

    // Without the enable the external bus stays quiet for the whole access
    chk_fast_off: assert property (
        (win_go && !i_fast_bulk_enable) |=> !o_ext_strobe ##1 !o_ext_strobe ##1 !o_ext_strobe)
        else $error("external strobe without fast bulk enable");

    // A fast read drives the same byte that the processor receives
    chk_fast_data: assert property (
        (win_read && fast_go) |=> ##1 !o_ext_data_oe ##1 o_ext_data_oe && o_ext_data == o_xrdata)
        else $error("fast read drove wrong external byte");

endmodule

`default_nettype wire

// file: bench/ram_model.sv
// Synchronous internal RAM that answers the pointer block's RAM port
`timescale 1ns/1ps
`default_nettype none

module ram_model
(
    // Clock
    input  wire logic        i_core_clk,
    // RAM port driven by the design
    input  wire logic [15:0] i_ram_addr,
    input  wire logic        i_ram_re,
    input  wire logic        i_ram_we,
    input  wire logic [7:0]  i_ram_wdata,
    // Read data, valid the cycle after a read enable
    output var  logic [7:0]  o_ram_rdata
);
    logic [7:0] mem [0:8191];

    // Outside a read the data toggles, so a late sample is never a lucky match
    always_ff @(posedge i_core_clk)
    begin
        if (i_ram_we)
            mem[i_ram_addr[12:0]] <= i_ram_wdata;
        if (i_ram_re)
            o_ram_rdata <= mem[i_ram_addr[12:0]];
        else
            o_ram_rdata <= ~o_ram_rdata;
    end
endmodule

`default_nettype wire

// file: bench/tb_top.sv
// Self-checking bench for the auto-increment RAM pointer
`timescale 1ns/1ps
`default_nettype none

module tb_top;
    import ram_ptr_pkg::*;

    // ****************************************
    // Stimulus and observed signals
    // ****************************************
    logic        i_core_clk         = 1'b0;
    logic        i_rst_b            = 1'b0;
    logic [15:0] i_xaddr            = 16'h0000;
    logic        i_xrd              = 1'b0;
    logic        i_xwr              = 1'b0;
    logic [7:0]  i_xwdata           = 8'h00;
    logic        i_fast_bulk_enable = 1'b0;
    logic [7:0]  i_ext_data         = 8'h00;
    logic [7:0]  o_xrdata;
    logic        o_xack;
    logic [7:0]  o_ext_data;
    logic        o_ext_data_oe;
    logic        o_ext_strobe;
    logic [15:0] o_ram_addr;
    logic        o_ram_re;
    logic        o_ram_we;
    logic [7:0]  o_ram_wdata;
    logic [7:0]  i_ram_rdata;
    logic [8:0]  exp_q [$];
    logic [7:0]  ext_q [$];
    logic [7:0]  dat [0:3];
    logic [8:0]  note;
    int          bad_count = 0;
    int          tests_run = 0;
    int          strobes   = 0;
    int          oob       = 0;
    int          rnd;

    always #10 i_core_clk = ~i_core_clk;

    ram_ptr_top ram_ptr_top_i (.i_core_clk(i_core_clk), .i_rst_b(i_rst_b),
        .i_xaddr(i_xaddr), .i_xrd(i_xrd), .i_xwr(i_xwr), .i_xwdata(i_xwdata),
        .o_xrdata(o_xrdata), .o_xack(o_xack), .i_fast_bulk_enable(i_fast_bulk_enable),
        .i_ext_data(i_ext_data), .o_ext_data(o_ext_data), .o_ext_data_oe(o_ext_data_oe),
        .o_ext_strobe(o_ext_strobe), .o_ram_addr(o_ram_addr), .o_ram_re(o_ram_re),
        .o_ram_we(o_ram_we), .o_ram_wdata(o_ram_wdata), .i_ram_rdata(i_ram_rdata));

    ram_model ram_model_i (.i_core_clk(i_core_clk), .i_ram_addr(o_ram_addr),
        .i_ram_re(o_ram_re), .i_ram_we(o_ram_we), .i_ram_wdata(o_ram_wdata),
        .o_ram_rdata(i_ram_rdata));

    // ****************************************
    // Shared tasks
    // ****************************************
    task automatic fail(input string m);
        $display("CHECK FAILED %0t %s", $time, m);
        bad_count++;
    endtask

    task automatic finish_test;
        $display("bad_count %0d tests_run %0d", bad_count, tests_run);
        if (bad_count == 0 && tests_run > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // One bus access; the note is queued before the strobe so the monitor finds it
    task automatic acc(input logic [15:0] a, input logic wr, input logic [7:0] d,
                       input logic chk, input logic [7:0] e);
        int n;
        @(negedge i_core_clk);
        exp_q.push_back({chk, e});
        i_xaddr = a;
        i_xwr = wr;
        i_xrd = !wr;
        i_xwdata = d;
        @(negedge i_core_clk);
        i_xwr = 1'b0;
        i_xrd = 1'b0;
        n = 0;
        while (o_xack !== 1'b1 && n < FAST_XFER_CYC)
        begin
            @(negedge i_core_clk);
            n++;
        end
        if (o_xack !== 1'b1) fail("no answer within deadline");
    endtask

    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        acc(a, 1'b1, d, 1'b0, 8'h00);
    endtask

    task automatic rd(input logic [15:0] a, input logic [7:0] e);
        acc(a, 1'b0, 8'h00, 1'b1, e);
    endtask

    task automatic setp(input logic [15:0] p);
        wr(ADDR_PTR_LOW, p[7:0]);
        wr(ADDR_PTR_HIGH, p[15:8]);
    endtask

    task automatic chkp(input logic [15:0] p);
        rd(ADDR_PTR_HIGH, p[15:8]);
        rd(ADDR_PTR_LOW, p[7:0]);
    endtask

    // ****************************************
    // Monitor: answers, strobes and RAM range
    // ****************************************
    always @(negedge i_core_clk)
    begin
        if (o_xack === 1'b1)
        begin
            tests_run++;
            if (exp_q.size() == 0)
                fail("answer without request");
            else
            begin
                note = exp_q.pop_front();
                if (note[8] && o_xrdata !== note[7:0]) fail("read data");
            end
        end
        if (o_ext_strobe === 1'b1)
        begin
            strobes++;
            if (o_ext_data_oe === 1'b1 && ext_q.size() > 0)
            begin
                tests_run++;
                if (o_ext_data !== ext_q.pop_front()) fail("external data");
            end
        end
        if ((o_ram_we === 1'b1 || o_ram_re === 1'b1) && o_ram_addr > RAM_TOP)
            oob++;
    end

    // Watchdog reckoned at about 37 times the expected run
    initial
    begin
        #(CLK_PERIOD_NS * 5000);
        fail("watchdog expired");
        finish_test();
    end

    // ****************************************
    // Main sequence
    // ****************************************
    initial
    begin
        rnd = $urandom(52856);
        repeat (10) @(negedge i_core_clk);
        i_rst_b = 1'b1;
        tests_run++;
        if (o_xack !== 1'b0 || o_ram_we !== 1'b0 || o_ext_strobe !== 1'b0) fail("reset");
        setp(16'h1234);
        chkp(16'h1234);
        // Stream across the low byte carry, then replay it
        setp(16'h00fe);
        for (int i = 0; i < 4; i++)
        begin
            dat[i] = 8'($urandom);
            wr(ADDR_DATA_WIN, dat[i]);
        end
        chkp(16'h0102);
        setp(16'h00fe);
        for (int i = 0; i < 4; i++)
            rd(ADDR_DATA_WIN, dat[i]);
        // Full wrap and accesses above internal RAM
        setp(16'hffff);
        rd(ADDR_DATA_WIN, 8'h00);
        chkp(16'h0000);
        setp(16'h2000);
        wr(ADDR_DATA_WIN, 8'h5a);
        // Fast bulk writes take the external byte, reads present it
        i_fast_bulk_enable = 1'b1;
        setp(16'h0400);
        for (int i = 0; i < 3; i++)
        begin
            dat[i] = 8'($urandom);
            i_ext_data = dat[i];
            wr(ADDR_DATA_WIN, ~dat[i]);
            i_ext_data = ~dat[i];
        end
        setp(16'h0400);
        for (int i = 0; i < 3; i++)
        begin
            ext_q.push_back(dat[i]);
            rd(ADDR_DATA_WIN, dat[i]);
        end
        // Disabled again: processor data goes to RAM, no external strobe
        i_fast_bulk_enable = 1'b0;
        setp(16'h0500);
        wr(ADDR_DATA_WIN, 8'hc3);
        setp(16'h0500);
        rd(ADDR_DATA_WIN, 8'hc3);
        repeat (4) @(negedge i_core_clk);
        tests_run += 3;
        if (strobes != 6) fail("fast strobe count");
        if (oob != 0) fail("RAM access above internal range");
        if (exp_q.size() != 0) fail("missing answers");
        finish_test();
    end
endmodule

`default_nettype wire
